// ### logic/ddr_lowpower_ctrl.sv
// sequencer for auto-precharge, power-down, self-refresh and refresh,
// plus the derived user and auxiliary clocks and the user reset.
// assumes user inputs synchronous to I_CLK, which runs at twice the
// memory interface rate and feeds the clock dividers.
`default_nettype none
module ddr_lowpower_ctrl
   import lp_pkg::*;
#(
   parameter bit AUTOPCH_EN = 1'b1,
   parameter bit POWERDN_EN = 1'b1,
   parameter bit SELF_RFSH_EN = 1'b1,
   parameter bit HALF_RATE = 1'b1,
   parameter int REFI_CYCLES = T_REFI_CYC
) (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire logic I_READ_REQ,
   input wire logic I_WRITE_REQ,
   input wire logic I_AUTOPCH_REQ,
   input wire logic I_POWERDN_REQ,
   input wire logic I_SELF_RFSH_REQ,
   output logic O_READY,
   output lp_pkg::mem_cmd_t O_MEM_CMD,
   output logic O_MEM_CKE,
   output logic O_REFRESH_ACK,
   output logic O_POWERDN_ACK,
   output logic O_SELF_RFSH_ACK,
   output logic O_USER_RESET_N,
   output logic O_USER_CLK,
   output logic O_AUX_FULL_CLK,
   output logic O_AUX_HALF_CLK,
   output logic O_DLL_REF_CLK
);
   import lp_pkg::*;

   lp_timer_if tif ();

   lp_refresh_timer #(.INTERVAL(REFI_CYCLES)) u_timer (
      .i_clk(I_CLK),
      .i_reset(I_RESET),
      .tif(tif)
   );

   lp_state_t state_reg, state_next;
   mem_cmd_t cmd_reg, cmd_next;
   logic [WAIT_W-1:0] wait_reg, wait_next;
   logic row_open_reg, row_open_next;
   logic cke_reg, cke_next;
   logic ready_reg;
   logic rf_ack_reg;
   logic pd_ack_reg, pd_ack_next;
   logic sr_ack_reg, sr_ack_next;
   logic [1:0] rst_sync_reg;
   logic [1:0] div_reg;
   logic user_clk_reg, full_clk_reg, half_clk_reg, dll_clk_reg;

   // ==========================================================
   // request decode
   wire logic pd_req = POWERDN_EN && I_POWERDN_REQ;
   wire logic sr_req = SELF_RFSH_EN && I_SELF_RFSH_REQ;
   wire logic use_ap = AUTOPCH_EN && I_AUTOPCH_REQ;
   wire logic take_rd = ready_reg && I_READ_REQ;
   wire logic take_wr = ready_reg && I_WRITE_REQ && !I_READ_REQ;
   wire logic wait_done = (wait_reg == WAIT_RST);
   wire logic need_pre = row_open_reg;
   wire logic [WAIT_W-1:0] wait_rp = WAIT_W'(T_RP_CYC - 1);
   wire logic [WAIT_W-1:0] wait_rfc = WAIT_W'(T_RFC_CYC - 1);
   wire logic [WAIT_W-1:0] wait_xp = WAIT_W'(T_XP_CYC - 1);
   wire logic [WAIT_W-1:0] wait_xsr = WAIT_W'(T_XSR_CYC - 1);
   wire logic [WAIT_W-1:0] wait_dec = wait_done ? WAIT_RST : wait_reg - WAIT_W'(1);
   wire logic ready_next = (state_next == ST_IDLE) && (cmd_next == CMD_NOP);

   // ==========================================================
   // sequencer: an accepted access goes first, then refresh, then
   // self-refresh, then power-down; every wait ends before new work
   always_comb begin
      state_next = state_reg;
      cmd_next = CMD_NOP;
      wait_next = wait_dec;
      row_open_next = row_open_reg;
      cke_next = cke_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (take_rd || take_wr) begin
               // auto-precharge variant closes the row in the memory
               cmd_next = take_rd ? (use_ap ? CMD_READ_AP : CMD_READ)
                                  : (use_ap ? CMD_WRITE_AP : CMD_WRITE);
               row_open_next = !use_ap;
            end else if (tif.due || sr_req || pd_req) begin
               if (need_pre) begin
                  cmd_next = CMD_PRECHARGE;
                  state_next = ST_PRE;
                  wait_next = wait_rp;
                  row_open_next = 1'b0;
               end else if (tif.due) begin
                  cmd_next = CMD_REFRESH;
                  state_next = ST_REF;
                  wait_next = wait_rfc;
               end else if (sr_req) begin
                  cmd_next = CMD_SR_ENTER;
                  state_next = ST_SR;
                  cke_next = 1'b0;
               end else begin
                  cmd_next = CMD_PD_ENTER;
                  state_next = ST_PD;
                  cke_next = 1'b0;
               end
            end
         end
         ST_PRE: begin
            if (wait_done) begin
               state_next = ST_IDLE;
            end
         end
         ST_REF: begin
            if (wait_done) begin
               state_next = ST_IDLE;
            end
         end
         ST_PD: begin
            // leave for a due refresh or when the user lets go
            if (tif.due || !pd_req) begin
               cmd_next = CMD_PD_EXIT;
               state_next = ST_PD_EXIT;
               wait_next = wait_xp;
               cke_next = 1'b1;
            end
         end
         ST_PD_EXIT: begin
            if (wait_done) begin
               state_next = ST_IDLE;
            end
         end
         ST_SR: begin
            // memory refreshes itself; only the user ends this
            if (!sr_req) begin
               cmd_next = CMD_SR_EXIT;
               state_next = ST_SR_EXIT;
               wait_next = wait_xsr;
               cke_next = 1'b1;
            end
         end
         ST_SR_EXIT: begin
            if (wait_done) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // refresh window restarts on each refresh and after self-refresh
   assign tif.restart = (cmd_reg == CMD_REFRESH) || (cmd_reg == CMD_SR_EXIT);

   // ==========================================================
   // acknowledges: set on entry, cleared only once back in idle
   // with cke high, so the memory is already out of the low-power state
   assign pd_ack_next = (cmd_next == CMD_PD_ENTER) ? 1'b1 :
                        (state_reg == ST_IDLE && !pd_req) ? 1'b0 : pd_ack_reg;
   assign sr_ack_next = (cmd_next == CMD_SR_ENTER) ? 1'b1 :
                        (state_reg == ST_IDLE && !sr_req) ? 1'b0 : sr_ack_reg;

   // ==========================================================
   // sequencer registers
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         state_reg <= ST_IDLE;
         cmd_reg <= CMD_NOP;
         wait_reg <= WAIT_RST;
         row_open_reg <= 1'b0;
         cke_reg <= 1'b1;
         ready_reg <= 1'b0;
         rf_ack_reg <= 1'b0;
         pd_ack_reg <= 1'b0;
         sr_ack_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cmd_reg <= cmd_next;
         wait_reg <= wait_next;
         row_open_reg <= row_open_next;
         cke_reg <= cke_next;
         ready_reg <= ready_next;
         rf_ack_reg <= (cmd_next == CMD_REFRESH);
         pd_ack_reg <= pd_ack_next;
         sr_ack_reg <= sr_ack_next;
      end
   end

   // ==========================================================
   // user reset: low from the reset edge, released two edges later
   // so every user flop sees a clean synchronous release
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   // ==========================================================
   // clock dividers; a flop-only design cannot multiply, so the
   // source clock is the double of the memory rate
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         div_reg <= CLKDIV_RST;
         user_clk_reg <= 1'b0;
         full_clk_reg <= 1'b0;
         half_clk_reg <= 1'b0;
         dll_clk_reg <= 1'b0;
      end else begin
         div_reg <= div_reg + 2'h1;
         full_clk_reg <= ~div_reg[0];
         half_clk_reg <= ~div_reg[1];
         dll_clk_reg <= ~div_reg[0];
         user_clk_reg <= HALF_RATE ? ~div_reg[1] : ~div_reg[0];
      end
   end

   assign O_READY = ready_reg;
   assign O_MEM_CMD = cmd_reg;
   assign O_MEM_CKE = cke_reg;
   assign O_REFRESH_ACK = rf_ack_reg;
   assign O_POWERDN_ACK = pd_ack_reg;
   assign O_SELF_RFSH_ACK = sr_ack_reg;
   assign O_USER_RESET_N = rst_sync_reg[1];
   assign O_USER_CLK = user_clk_reg;
   assign O_AUX_FULL_CLK = full_clk_reg;
   assign O_AUX_HALF_CLK = half_clk_reg;
   assign O_DLL_REF_CLK = dll_clk_reg;

   // ==========================================================
   // assertions
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);

   a_refresh_one_cycle: assert property (O_REFRESH_ACK |=> !O_REFRESH_ACK)
      else $error("refresh acknowledge longer than one cycle");
   a_refresh_window: assert property (O_REFRESH_ACK |=> state_reg == ST_REF)
      else $error("refresh acknowledge without refresh wait");
   a_ap_read_variant: assert property
      (state_reg == ST_IDLE && take_rd && use_ap |=> O_MEM_CMD == CMD_READ_AP)
      else $error("auto-precharge read not issued");
   a_ap_option_off: assert property
      (!AUTOPCH_EN |-> O_MEM_CMD != CMD_READ_AP && O_MEM_CMD != CMD_WRITE_AP)
      else $error("auto-precharge used with option off");
   a_pd_ack_entry: assert property
      (O_MEM_CMD == CMD_PD_ENTER |-> O_POWERDN_ACK && !O_MEM_CKE)
      else $error("power-down entered without acknowledge");
   a_pd_refresh_exit: assert property
      (state_reg == ST_PD && tif.due |=> O_MEM_CMD == CMD_PD_EXIT)
      else $error("power-down not left for refresh");
   a_pd_ack_release: assert property
      ($fell(O_POWERDN_ACK) |-> O_MEM_CKE && $past(state_reg) == ST_IDLE)
      else $error("power-down acknowledge dropped early");
   a_sr_ack_release: assert property
      ($fell(O_SELF_RFSH_ACK) |-> O_MEM_CKE && $past(state_reg) == ST_IDLE)
      else $error("self-refresh acknowledge dropped early");
   a_sr_exit_bound: assert property
      (O_MEM_CMD == CMD_SR_EXIT |-> ##[1:210] state_reg == ST_IDLE)
      else $error("self-refresh exit too slow");
   a_half_clk_rate: assert property
      ($changed(O_AUX_HALF_CLK) |=> $stable(O_AUX_HALF_CLK) ##1 $changed(O_AUX_HALF_CLK))
      else $error("half-rate aux clock wrong period");

   c_pd_refresh: cover property (state_reg == ST_PD ##1 O_MEM_CMD == CMD_PD_EXIT ##[1:8]
                                 O_REFRESH_ACK);
   c_sr_cycle: cover property (O_SELF_RFSH_ACK ##[1:300] $fell(O_SELF_RFSH_ACK));
   c_ap_write: cover property (O_MEM_CMD == CMD_WRITE_AP);
endmodule : ddr_lowpower_ctrl
`default_nettype wire

// ### common/lp_pkg.sv
// package of the low-power / refresh sequencer: commands, states, timing.
// assumes a single user clock at 200 MHz and synchronous inputs.
`default_nettype none
package lp_pkg;
   // ==========================================================
   // clock and memory timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int T_RP_PS = 15000;     // precharge to next command, least time
   localparam int T_RFC_PS = 105000;   // refresh cycle, least time
   localparam int T_XP_PS = 7500;      // power-down exit, least time
   localparam int T_XSR_PS = 1000000;  // self-refresh exit, least time
   localparam int T_REFI_PS = 7800000; // refresh interval, longest time
   // least times round up, the interval rounds down
   localparam int T_RP_CYC = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_RFC_CYC = (T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_XP_CYC = (T_XP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_XSR_CYC = (T_XSR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T_REFI_CYC = T_REFI_PS / CLK_PERIOD_PS;
   localparam int WAIT_W = 8;
   localparam int REFI_W = 11;

   // ==========================================================
   // memory commands presented on the command port
   typedef enum logic [3:0] {
      CMD_NOP = 4'h0,
      CMD_READ = 4'h1,
      CMD_WRITE = 4'h2,
      CMD_READ_AP = 4'h3,
      CMD_WRITE_AP = 4'h4,
      CMD_PRECHARGE = 4'h5,
      CMD_REFRESH = 4'h6,
      CMD_PD_ENTER = 4'h7,
      CMD_PD_EXIT = 4'h8,
      CMD_SR_ENTER = 4'h9,
      CMD_SR_EXIT = 4'hA
   } mem_cmd_t;

   // ==========================================================
   // sequencer states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_PRE = 7'h02,
      ST_REF = 7'h04,
      ST_PD = 7'h08,
      ST_PD_EXIT = 7'h10,
      ST_SR = 7'h20,
      ST_SR_EXIT = 7'h40
   } lp_state_t;

   localparam logic [WAIT_W-1:0] WAIT_RST = 8'h00;
   localparam logic [1:0] CLKDIV_RST = 2'h0;
endpackage : lp_pkg
`default_nettype wire

// ### common/lp_timer_if.sv
// carrier between the sequencer and its refresh interval timer.
// assumes both ends sit on the same clock.
`default_nettype none
interface lp_timer_if;
   logic due;     // refresh interval elapsed, sticky
   logic restart; // refresh issued or self-refresh left
   modport ctrl (input due, output restart);
   modport timer (output due, input restart);
endinterface : lp_timer_if
`default_nettype wire

// ### logic/lp_refresh_timer.sv
// refresh interval timer: raises a sticky due flag every interval.
// assumes restart is a one-cycle pulse from the sequencer.
`default_nettype none
module lp_refresh_timer
   import lp_pkg::*;
#(
   parameter int INTERVAL = T_REFI_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset,
   lp_timer_if.timer tif
);
   logic [REFI_W-1:0] count_reg;
   logic due_reg;
   wire logic count_end = (count_reg == REFI_W'(INTERVAL - 1));

   // ==========================================================
   // interval count; restart realigns the window to the last refresh
   always_ff @(posedge i_clk) begin
      if (i_reset || tif.restart || count_end) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_reg + REFI_W'(1);
      end
   end

   // set wins over restart so an elapsed interval is never dropped
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         due_reg <= 1'b0;
      end else if (count_end) begin
         due_reg <= 1'b1;
      end else if (tif.restart) begin
         due_reg <= 1'b0;
      end
   end

   assign tif.due = due_reg;
endmodule : lp_refresh_timer
`default_nettype wire

// ### test/lp_user_model.sv
// user-side master model: access requests and low-power request levels.
// assumes the controller samples its inputs on the rising edge of i_clk.
`default_nettype none
module lp_user_model (
   input wire logic i_clk,
   input wire logic i_ready,
   output logic o_read_req,
   output logic o_write_req,
   output logic o_autopch_req,
   output logic o_powerdn_req,
   output logic o_self_rfsh_req
);
   timeunit 1ns;
   timeprecision 1ps;
   bit pend = 1'b0;
   logic rd_q = 1'b0;
   logic ap_q = 1'b0;
   logic pd_q = 1'b0;
   logic sr_q = 1'b0;

   initial begin
      o_read_req = 1'b0;
      o_write_req = 1'b0;
      o_autopch_req = 1'b0;
      o_powerdn_req = 1'b0;
      o_self_rfsh_req = 1'b0;
   end

   // ==========================================================
   // drive on the rising edge; a request holds until it is taken
   always @(posedge i_clk) begin
      if (pend && (o_read_req || o_write_req) && i_ready) begin
         pend = 1'b0; // taken at this edge
      end
      o_read_req <= pend & rd_q;
      o_write_req <= pend & ~rd_q;
      // idle qualifier toggles so a leak past the request shows up
      o_autopch_req <= pend ? ap_q : ~o_autopch_req;
      o_powerdn_req <= pd_q;
      o_self_rfsh_req <= sr_q;
   end

   // ==========================================================
   // bench-facing tasks, stepping on falling edges to avoid races
   task automatic access(input logic rd, input logic ap, output bit ok);
      int n;
      @(negedge i_clk);
      rd_q = rd;
      ap_q = ap;
      pend = 1'b1;
      ok = 1'b0;
      for (n = 0; n < 40 && !ok; n++) begin
         @(negedge i_clk);
         ok = !pend;
      end
      pend = 1'b0;
   endtask : access

   task automatic set_lp(input logic pd, input logic sr);
      @(negedge i_clk);
      pd_q = pd;
      sr_q = sr;
   endtask : set_lp
endmodule : lp_user_model
`default_nettype wire

// ### test/tb_ddr_lowpower_ctrl.sv
// self-checking bench of the low-power and refresh sequencer.
// assumes lp_pkg and the user master model lp_user_model.
`default_nettype none
module tb_ddr_lowpower_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import lp_pkg::*;
   localparam int REFI = 60; // short interval keeps the run brief
   logic I_CLK = 1'b0;
   logic I_RESET = 1'b1;
   logic rd_req, wr_req, ap_req, pd_req, sr_req;
   logic ready, cke, rf_ack, pd_ack, sr_ack, urst_n, uclk, fclk, hclk, dclk;
   logic pd_ack_q = 1'b0;
   logic sr_ack_q = 1'b0;
   mem_cmd_t cmd;
   int miscompares = 0;
   int total_checks = 0;
   int rf_cnt = 0;
   bit exit_seen = 1'b0;
   logic [31:0] seed = 32'h0000DC79;

   initial begin
      forever #2.5 I_CLK = ~I_CLK;
   end

   lp_user_model user (.i_clk(I_CLK), .i_ready(ready), .o_read_req(rd_req),
      .o_write_req(wr_req), .o_autopch_req(ap_req), .o_powerdn_req(pd_req),
      .o_self_rfsh_req(sr_req));

   ddr_lowpower_ctrl #(.REFI_CYCLES(REFI)) DUT (.I_CLK(I_CLK), .I_RESET(I_RESET),
      .I_READ_REQ(rd_req), .I_WRITE_REQ(wr_req), .I_AUTOPCH_REQ(ap_req),
      .I_POWERDN_REQ(pd_req), .I_SELF_RFSH_REQ(sr_req), .O_READY(ready),
      .O_MEM_CMD(cmd), .O_MEM_CKE(cke), .O_REFRESH_ACK(rf_ack), .O_POWERDN_ACK(pd_ack),
      .O_SELF_RFSH_ACK(sr_ack), .O_USER_RESET_N(urst_n), .O_USER_CLK(uclk),
      .O_AUX_FULL_CLK(fclk), .O_AUX_HALF_CLK(hclk), .O_DLL_REF_CLK(dclk));

   // ==========================================================
   // expectation helpers and reporting
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   function automatic mem_cmd_t exp_cmd(input logic rd, input logic ap);
      if (rd) return ap ? CMD_READ_AP : CMD_READ;
      return ap ? CMD_WRITE_AP : CMD_WRITE;
   endfunction : exp_cmd

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   task automatic timeout();
      miscompares++;
      $display("timeout t=%0t", $time);
      give_verdict();
   endtask : timeout

   task automatic wait_cmd(input mem_cmd_t c, input int bound);
      int n;
      for (n = 0; n < bound; n++) begin
         @(posedge I_CLK);
         if (cmd === c) return;
      end
      timeout();
   endtask : wait_cmd

   // ==========================================================
   // monitor: refresh pulse pairing and acknowledge release order
   always @(posedge I_CLK) begin
      if (!I_RESET) begin
         if (rf_ack === 1'b1 || cmd === CMD_REFRESH) check(rf_ack, cmd === CMD_REFRESH);
         if (rf_ack === 1'b1) rf_cnt++;
         if (cmd === CMD_PD_EXIT || cmd === CMD_SR_EXIT) exit_seen = 1'b1;
         if (cmd === CMD_PD_ENTER || cmd === CMD_SR_ENTER) exit_seen = 1'b0;
         if (pd_ack_q && pd_ack === 1'b0) check({pd_req, exit_seen, cke}, 3'h3);
         if (sr_ack_q && sr_ack === 1'b0) check({sr_req, exit_seen, cke}, 3'h3);
      end
      pd_ack_q = (pd_ack === 1'b1);
      sr_ack_q = (sr_ack === 1'b1);
   end

   // ==========================================================
   // main sequence
   initial begin
      int n;
      int rf0;
      bit ok;
      logic rd, ap;
      logic [3:0] pv, nv;
      int tg [4];
      repeat (4) @(posedge I_CLK);
      check({urst_n, pd_ack, sr_ack, rf_ack}, 4'h0);
      check(cmd, CMD_NOP);
      @(posedge I_CLK);
      I_RESET <= 1'b0;
      for (n = 0; n < 4 && urst_n !== 1'b1; n++) @(posedge I_CLK);
      if (n == 4) timeout();
      // random accesses, gaps of zero still leave two idle cycles between commands
      repeat (24) begin
         seed = xs(seed);
         rd = seed[0];
         ap = seed[1];
         user.access(rd, ap, ok);
         if (!ok) timeout();
         @(posedge I_CLK);
         check(cmd, exp_cmd(rd, ap));
         repeat (seed[4:2]) @(posedge I_CLK);
      end
      wait_cmd(CMD_REFRESH, REFI + 40);
      check(rf_ack, 1'b1);
      // power-down held across several refresh intervals
      user.set_lp(1'b1, 1'b0);
      wait_cmd(CMD_PD_ENTER, 40);
      check({pd_ack, cke}, 2'h2);
      rf0 = rf_cnt;
      repeat (3 * REFI) @(posedge I_CLK);
      check(rf_cnt > rf0 + 1, 1'b1);
      check(pd_ack, 1'b1);
      user.set_lp(1'b0, 1'b0);
      for (n = 0; n < REFI + 40 && pd_ack !== 1'b0; n++) @(posedge I_CLK);
      if (n == REFI + 40) timeout();
      // self-refresh asked for after a plain read is taken and leaves its row open
      user.access(1'b1, 1'b0, ok);
      if (!ok) timeout();
      user.set_lp(1'b0, 1'b1);
      wait_cmd(CMD_SR_ENTER, 40);
      check({sr_ack, cke}, 2'h2);
      repeat (2 * REFI) @(posedge I_CLK);
      check(sr_ack, 1'b1);
      user.set_lp(1'b0, 1'b0);
      for (n = 0; n < 300 && sr_ack !== 1'b0; n++) @(posedge I_CLK);
      if (n == 300) timeout();
      // derived clocks: count toggles over sixteen cycles
      tg = '{0, 0, 0, 0};
      @(posedge I_CLK);
      pv = {uclk, fclk, hclk, dclk};
      repeat (16) begin
         @(posedge I_CLK);
         nv = {uclk, fclk, hclk, dclk};
         for (n = 0; n < 4; n++) tg[n] += int'(pv[3-n] !== nv[3-n]);
         pv = nv;
      end
      check(tg[0], 8);
      check(tg[1], 16);
      check(tg[2], 8);
      check(tg[3], 16);
      give_verdict();
   end
endmodule : tb_ddr_lowpower_ctrl
`default_nettype wire
